// File: rtl/icps_pkg.sv
// Constants and types shared by the isolated channel and power sequencer.
package icps_pkg;
  // Four isolated lanes; a set bit marks a lane sent from the secondary side.
  localparam int              LANES         = 4;
  localparam logic [LANES-1:0] LANE_FROM_SEC = 4'hC;
  // Clock period in picoseconds (250 MHz).
  localparam int CLK_PS       = 4000;
  // Idle time before refresh pulses start; a least time, so it rounds up.
  localparam int REFRESH_NS   = 1000;
  localparam int REFRESH_CYC  = (REFRESH_NS * 1000 + CLK_PS - 1) / CLK_PS;
  // Receive watchdog timeout; a longest time, so it rounds down.
  localparam int WATCHDOG_NS  = 5000;
  localparam int WATCHDOG_CYC = (WATCHDOG_NS * 1000) / CLK_PS;
  // Converter off time after a short circuit.
  localparam int OFF_TIME_MS  = 2;
  localparam int OFF_TIME_CYC = OFF_TIME_MS * (1000000000 / CLK_PS);
  // Converter oscillator period and per-switch half period.
  localparam int OSC_NS       = 2000;
  localparam int OSC_CYC      = (OSC_NS * 1000) / CLK_PS;
  localparam int HALF_CYC     = OSC_CYC / 2;
  localparam int DEAD_CYC     = 2;
  localparam int WIDTH_MAX    = HALF_CYC - DEAD_CYC;
  localparam logic [7:0] SS_STEP = 8'h01;
  // Barrier slot rate and pulse buffer depth.
  localparam int SLOT_DIV     = 2;
  localparam int FIFO_DEPTH   = 4;
  // Counter widths.
  localparam int REF_W = 9;
  localparam int WD_W  = 11;
  localparam int OSC_W = 9;
  localparam int HIC_W = 20;
  localparam int WID_W = 8;

  // One barrier word: a set pulse and a clear pulse per lane.
  typedef struct packed {
    logic [LANES-1:0] rise;
    logic [LANES-1:0] fall;
  } icps_pulse_t;

  // Supply and die temperature comparator levels.
  typedef struct packed {
    logic pri_ok;
    logic sec_ok;
    logic temp_trip;
    logic temp_clear;
  } icps_supply_t;

  // Converter modes, Gray coded along off, soft start, normal, hiccup.
  typedef enum logic [1:0] {
    CV_OFF    = 2'b00,
    CV_SOFT   = 2'b01,
    CV_NORMAL = 2'b11,
    CV_HICCUP = 2'b10
  } icps_conv_t;
endpackage : icps_pkg

// File: rtl/icps_top.sv
// Isolated lanes, barrier pulse buffer and isolated supply sequencer.
`timescale 1ns/1ps

module icps_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic [PW-1:0]    next_wr_ptr;
  logic [PW-1:0]    next_rd_ptr;
  logic [CW-1:0]    next_count;
  logic             push;
  logic             pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready  = (count != CW'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointer wrap and count update.
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  // The storage array needs no reset; only the pointers and the count do.
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end
endmodule : icps_fifo

module icps_top #(
  parameter int HICCUP_CYC = icps_pkg::OFF_TIME_CYC
) (
  input  wire logic                       sys_clk,
  input  wire logic                       reset_n,
  input  wire icps_pkg::icps_supply_t     supply,
  input  wire logic [icps_pkg::LANES-1:0] data_in,
  input  wire logic                       iso_above_startup,
  input  wire logic                       short_detect,
  input  wire logic                       over_current,
  input  wire logic [icps_pkg::WID_W-1:0] sec_pwm_width,
  output logic      [icps_pkg::LANES-1:0] data_out,
  output logic                            primary_switch_a,
  output logic                            primary_switch_b,
  output icps_pkg::icps_conv_t            conv_mode
);
  import icps_pkg::*;

  logic             hot;
  logic             next_hot;
  logic [LANES-1:0] src_on;
  logic [LANES-1:0] dst_on;
  logic [LANES-1:0] last_sent;
  logic [LANES-1:0] next_last_sent;
  logic [REF_W-1:0] idle [LANES];
  logic [REF_W-1:0] next_idle [LANES];
  icps_pulse_t      push_word;
  logic             push_valid;
  logic             fifo_in_ready;
  logic             fifo_out_valid;
  icps_pulse_t      rx_word;
  logic [1:0]       slot_cnt;
  logic [1:0]       next_slot_cnt;
  logic             slot_en;
  logic             pop;
  logic [WD_W-1:0]  wd [LANES];
  logic [WD_W-1:0]  next_wd [LANES];
  logic [LANES-1:0] next_data_out;
  icps_conv_t       next_mode;
  logic [OSC_W-1:0] osc;
  logic [OSC_W-1:0] next_osc;
  logic [OSC_W-1:0] phase_pos;
  logic [WID_W-1:0] width;
  logic [WID_W-1:0] next_width;
  logic [HIC_W-1:0] hic;
  logic [HIC_W-1:0] next_hic;
  logic             lim;
  logic             next_lim;
  logic             first_half;
  logic             run;
  logic             drive;
  logic             next_sw_a;
  logic             next_sw_b;

  // Thermal latch with hysteresis between the trip and clear comparators.
  always_comb begin
    next_hot = hot;
    if (supply.temp_trip) begin
      next_hot = 1'b1;
    end else if (supply.temp_clear) begin
      next_hot = 1'b0;
    end
  end

  // A lane's sender and receiver are each powered by their own side.
  for (genvar g = 0; g < LANES; g++) begin : g_side
    assign src_on[g] = LANE_FROM_SEC[g] ? supply.sec_ok : supply.pri_ok;
    assign dst_on[g] = LANE_FROM_SEC[g] ? supply.pri_ok : supply.sec_ok;
  end

  // Edge and refresh encoder. A full buffer stalls the encoder, so an edge
  // is delayed rather than dropped; the level compare re-sends it later.
  always_comb begin
    push_word      = '0;
    next_last_sent = last_sent;
    for (int i = 0; i < LANES; i++) begin
      next_idle[i] = idle[i];
      if (!src_on[i]) begin
        next_last_sent[i] = 1'b0;
        next_idle[i]      = '0;
      end else if (data_in[i] != last_sent[i] || idle[i] >= REF_W'(REFRESH_CYC)) begin
        push_word.rise[i] = data_in[i];
        push_word.fall[i] = !data_in[i];
        if (fifo_in_ready) begin
          next_last_sent[i] = data_in[i];
          next_idle[i]      = '0;
        end
      end else begin
        next_idle[i] = idle[i] + 1'b1;
      end
    end
  end
  assign push_valid = (push_word != '0);

  // The barrier carries one word every SLOT_DIV cycles.
  assign slot_en       = (slot_cnt == 2'(SLOT_DIV - 1));
  assign next_slot_cnt = slot_en ? 2'h0 : slot_cnt + 2'h1;
  assign pop           = fifo_out_valid && slot_en;

  icps_fifo #(
    .WIDTH ($bits(icps_pulse_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_barrier (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .in_valid  (push_valid),
    .in_data   (push_word),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_out_valid),
    .out_data  (rx_word),
    .out_ready (slot_en)
  );

  // Bistable decoders with watchdog; a pulse always restarts the watchdog.
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      next_data_out[i] = data_out[i];
      next_wd[i]       = (wd[i] == '1) ? wd[i] : wd[i] + 1'b1;
      if (pop && (rx_word.rise[i] || rx_word.fall[i])) begin
        next_data_out[i] = rx_word.rise[i];
        next_wd[i]       = '0;
      end else if (wd[i] >= WD_W'(WATCHDOG_CYC)) begin
        next_data_out[i] = 1'b0;
      end
      if (!dst_on[i] || hot) begin
        next_data_out[i] = 1'b0;
        next_wd[i]       = '0;
      end
    end
  end

  // Converter mode sequencing.
  always_comb begin
    next_mode  = conv_mode;
    next_width = width;
    next_hic   = '0;
    case (conv_mode)
      CV_OFF: begin
        next_width = '0;
        next_mode  = CV_SOFT;
      end
      CV_SOFT: begin
        if (short_detect) begin
          next_mode = CV_HICCUP;
        end else if (iso_above_startup) begin
          next_mode = CV_NORMAL;
        end else if (osc == '0 && width < WID_W'(WIDTH_MAX)) begin
          next_width = width + SS_STEP;
        end
      end
      CV_NORMAL: begin
        if (short_detect) begin
          next_mode = CV_HICCUP;
        end else if (sec_pwm_width > WID_W'(WIDTH_MAX)) begin
          next_width = WID_W'(WIDTH_MAX);
        end else begin
          next_width = sec_pwm_width;
        end
      end
      default: begin
        next_hic = hic + 1'b1;
        if (hic == HIC_W'(HICCUP_CYC - 1)) begin
          next_mode  = CV_SOFT;
          next_width = '0;
        end
      end
    endcase
    if (!supply.pri_ok || hot) begin
      next_mode = CV_OFF;
    end
  end

  // Oscillator runs only while switching, so lockout and hiccup stop it.
  assign run        = (next_mode == CV_SOFT) || (next_mode == CV_NORMAL);
  assign first_half = (osc < OSC_W'(HALF_CYC));
  assign phase_pos  = first_half ? osc : osc - OSC_W'(HALF_CYC);
  always_comb begin
    next_osc = '0;
    if (run && osc != OSC_W'(OSC_CYC - 1)) begin
      next_osc = osc + 1'b1;
    end
    next_lim = lim || over_current;
    if (osc == '0 || osc == OSC_W'(HALF_CYC)) begin
      next_lim = over_current;
    end
    drive     = run && (phase_pos < OSC_W'(width)) && !lim && !over_current;
    next_sw_a = drive && first_half;
    next_sw_b = drive && !first_half;
  end

  // All state registers.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      hot              <= 1'b0;
      last_sent        <= '0;
      slot_cnt         <= 2'h0;
      data_out         <= '0;
      conv_mode        <= CV_OFF;
      osc              <= '0;
      width            <= '0;
      hic              <= '0;
      lim              <= 1'b0;
      primary_switch_a <= 1'b0;
      primary_switch_b <= 1'b0;
      for (int i = 0; i < LANES; i++) begin
        idle[i] <= '0;
        wd[i]   <= '0;
      end
    end else begin
      hot              <= next_hot;
      last_sent        <= next_last_sent;
      slot_cnt         <= next_slot_cnt;
      data_out         <= next_data_out;
      conv_mode        <= next_mode;
      osc              <= next_osc;
      width            <= next_width;
      hic              <= next_hic;
      lim              <= next_lim;
      primary_switch_a <= next_sw_a;
      primary_switch_b <= next_sw_b;
      for (int i = 0; i < LANES; i++) begin
        idle[i] <= next_idle[i];
        wd[i]   <= next_wd[i];
      end
    end
  end

  // Per-lane checks of the encoder and decoder.
  for (genvar g = 0; g < LANES; g++) begin : g_chk
    property p_edge_sent;
      @(posedge sys_clk) disable iff (!reset_n)
      src_on[g] && data_in[g] != last_sent[g] && fifo_in_ready
        |=> last_sent[g] == $past(data_in[g]);
    endproperty
    a_edge_sent: assert property (p_edge_sent) else $error("edge not sent");
    property p_refresh;
      @(posedge sys_clk) disable iff (!reset_n)
      src_on[g] && idle[g] >= REF_W'(REFRESH_CYC)
        |-> push_word.rise[g] == data_in[g] && push_word.fall[g] == !data_in[g];
    endproperty
    a_refresh: assert property (p_refresh) else $error("refresh missing");
    property p_set;
      @(posedge sys_clk) disable iff (!reset_n)
      pop && rx_word.rise[g] && dst_on[g] && !hot && !supply.temp_trip |=> data_out[g];
    endproperty
    a_set: assert property (p_set) else $error("decoder not set");
    property p_watchdog;
      @(posedge sys_clk) disable iff (!reset_n)
      wd[g] >= WD_W'(WATCHDOG_CYC) && !(pop && (rx_word.rise[g] || rx_word.fall[g]))
        |=> !data_out[g];
    endproperty
    a_watchdog: assert property (p_watchdog) else $error("watchdog missed");
  end

  // Converter checks.
  sequence s_short_hit;
    (conv_mode == CV_SOFT || conv_mode == CV_NORMAL) && short_detect
      && supply.pri_ok && !hot && !supply.temp_trip;
  endsequence
  sequence s_drive_off;
    conv_mode == CV_HICCUP ##0 (!primary_switch_a && !primary_switch_b) [*8];
  endsequence
  property p_hiccup;
    @(posedge sys_clk) disable iff (!reset_n) s_short_hit |=> s_drive_off;
  endproperty
  a_hiccup: assert property (p_hiccup) else $error("hiccup not entered");
  property p_restart;
    @(posedge sys_clk) disable iff (!reset_n)
    conv_mode == CV_HICCUP && hic == HIC_W'(HICCUP_CYC - 1) && supply.pri_ok
      && !hot && !supply.temp_trip |=> conv_mode == CV_SOFT && width == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart");
  property p_ramp;
    @(posedge sys_clk) disable iff (!reset_n)
    conv_mode == CV_SOFT && osc == '0 && !short_detect && !iso_above_startup
      && width < WID_W'(WIDTH_MAX) && supply.pri_ok && !hot && !supply.temp_trip
      |=> width == $past(width) + SS_STEP;
  endproperty
  a_ramp: assert property (p_ramp) else $error("soft start stalled");
  property p_ilimit;
    @(posedge sys_clk) disable iff (!reset_n)
    over_current |=> !primary_switch_a && !primary_switch_b;
  endproperty
  a_ilimit: assert property (p_ilimit) else $error("pulse not cut");
  property p_lockout;
    @(posedge sys_clk) disable iff (!reset_n)
    !supply.pri_ok |=> conv_mode == CV_OFF && !primary_switch_a && !primary_switch_b
      && (data_out & LANE_FROM_SEC) == '0;
  endproperty
  a_lockout: assert property (p_lockout) else $error("lockout ignored");
  property p_thermal;
    @(posedge sys_clk) disable iff (!reset_n)
    hot |=> data_out == '0 && !primary_switch_a && !primary_switch_b;
  endproperty
  a_thermal: assert property (p_thermal) else $error("thermal ignored");
endmodule : icps_top

// File: tb/icps_sec_model.sv
// Secondary-side controller model: isolated rail state and pulse width feedback.
`timescale 1ns/1ps
module icps_sec_model #(
  parameter int               UP_PULSES = 8,
  parameter logic [7:0]       PWM       = 8'h40
) (
  input  wire logic                       sys_clk,
  input  wire logic                       reset_n,
  input  wire logic                       enable,
  input  wire icps_pkg::icps_conv_t       conv_mode,
  input  wire logic                       primary_switch_a,
  output logic                            iso_above_startup,
  output logic      [icps_pkg::WID_W-1:0] sec_pwm_width
);
  import icps_pkg::*;
  int   pulses;
  logic last_a;

  // The rail climbs only on drive pulses; it drains while off or in hiccup.
  always_ff @(posedge sys_clk) begin
    last_a <= primary_switch_a;
    if (!reset_n || !enable || conv_mode == CV_OFF || conv_mode == CV_HICCUP) begin
      pulses            <= 0;
      iso_above_startup <= 1'b0;
    end else if (primary_switch_a && !last_a && pulses < UP_PULSES) begin
      pulses <= pulses + 1;
    end else if (pulses == UP_PULSES) begin
      iso_above_startup <= 1'b1;
    end
  end

  // A fixed regulation width keeps the expected on time exact.
  assign sec_pwm_width = PWM;
endmodule : icps_sec_model

// File: tb/tb.sv
// Self-checking bench for the isolated lanes and supply sequencer.
`timescale 1ns/1ps
module tb;
  import icps_pkg::*;
  localparam int         HC  = 50;
  localparam logic [7:0] PWM = 8'h40;
  logic             sys_clk      = 1'b0;
  logic             reset_n      = 1'b0;
  icps_supply_t     supply       = '0;
  logic [LANES-1:0] data_in      = 4'hA;
  logic             short_detect = 1'b0;
  logic             over_current = 1'b0;
  logic             partner_en   = 1'b0;
  logic             iso_above_startup;
  logic [WID_W-1:0] sec_pwm_width;
  logic [LANES-1:0] data_out;
  logic             primary_switch_a;
  logic             primary_switch_b;
  icps_conv_t       conv_mode;
  logic [LANES-1:0] exp_q[$];
  logic [LANES-1:0] seen         = 4'h0;
  int               fails        = 0;
  int               checks_done  = 0;
  int               n;
  int               w1;
  int               w2;

  always #2 sys_clk = ~sys_clk;

  icps_top #(.HICCUP_CYC(HC)) u_dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .supply(supply), .data_in(data_in),
    .iso_above_startup(iso_above_startup), .short_detect(short_detect),
    .over_current(over_current), .sec_pwm_width(sec_pwm_width), .data_out(data_out),
    .primary_switch_a(primary_switch_a), .primary_switch_b(primary_switch_b),
    .conv_mode(conv_mode)
  );

  icps_sec_model #(.PWM(PWM)) u_sec (
    .sys_clk(sys_clk), .reset_n(reset_n), .enable(partner_en), .conv_mode(conv_mode),
    .primary_switch_a(primary_switch_a), .iso_above_startup(iso_above_startup),
    .sec_pwm_width(sec_pwm_width)
  );

  task automatic check(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      fails++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : check

  task automatic cyc(input int k);
    repeat (k) @(negedge sys_clk);
  endtask : cyc

  task automatic final_report;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  // Waits until every noted lane result was seen; k tells how long it took.
  task automatic drain(input int lim, output int k);
    k = 0;
    while (exp_q.size() != 0 && k < lim) begin
      cyc(1);
      k++;
    end
    check(exp_q.size() == 0, "lane result missing");
  endtask : drain

  task automatic wait_mode(input icps_conv_t m, input int lim, output int k);
    k = 0;
    while (conv_mode !== m && k < lim) begin
      cyc(1);
      k++;
    end
  endtask : wait_mode

  // Stops at the first cycle of the next switch A drive pulse.
  task automatic a_rise;
    n = 0;
    while (primary_switch_a !== 1'b0 && n < 600) begin
      cyc(1);
      n++;
    end
    while (primary_switch_a !== 1'b1 && n < 1200) begin
      cyc(1);
      n++;
    end
  endtask : a_rise

  task automatic a_width(output int w);
    a_rise();
    w = 0;
    while (primary_switch_a === 1'b1 && w < 300) begin
      cyc(1);
      w++;
    end
  endtask : a_width

  // Every change on the lane outputs must match the oldest noted result.
  always @(negedge sys_clk) begin
    if (data_out !== seen) begin
      if (exp_q.size() == 0) begin
        check(1'b0, "unexpected lane change");
      end else begin
        check(data_out === exp_q.pop_front(), "lane value wrong");
      end
      seen = data_out;
    end
  end

  // Cuts a hang short; the sequence needs far less than this span.
  initial begin
    #200000;
    fails++;
    final_report();
  end

  initial begin
    void'($urandom(32'h8f2d));
    cyc(16);
    reset_n = 1'b1;
    cyc(100);
    check(data_out === 4'h0 && conv_mode === CV_OFF && primary_switch_a === 1'b0
          && primary_switch_b === 1'b0, "activity in lockout");
    supply.pri_ok = 1'b1;
    cyc(1);
    check(conv_mode === CV_SOFT, "no soft start");
    cyc(300);
    check(data_out === 4'h0, "output before pulses");
    a_width(w1);
    a_width(w2);
    check(w1 > 0 && w2 == w1 + 1, "soft start not widening");
    // Lanes 0 and 1 flip together while the secondary is down, so their
    // refresh counters run in step and the secondary wakes in one change.
    data_in = 4'h1;
    cyc(8);
    supply.sec_ok = 1'b1;
    exp_q.push_back(4'h1);
    drain(REFRESH_CYC + 12, n);
    partner_en = 1'b1;
    wait_mode(CV_NORMAL, 6000, n);
    check(conv_mode === CV_NORMAL, "no hand-over");
    a_width(w1);
    check(w1 == int'(PWM), "width not from secondary");
    // Switch B gets the same width in the second half of the period.
    w2 = 0;
    repeat (400) begin
      w2 += int'(primary_switch_b);
      cyc(1);
    end
    check(w2 == int'(PWM), "switch B width wrong");
    // Traffic only once the isolated rail is up; several lanes flip together.
    for (int i = 0; i < 16; i++) begin
      w1 = $urandom;
      data_in = (w1[3:0] == data_in) ? ~data_in : w1[3:0];
      exp_q.push_back(data_in);
      drain(30, n);
      cyc(4);
    end
    // Flip every lane at once so all refresh counters run in step; later
    // steps expect the lanes to wake or time out in a single change.
    if (data_in != 4'hC) begin
      data_in = 4'hC;
      exp_q.push_back(4'hC);
      drain(30, n);
    end
    data_in = 4'h3;
    exp_q.push_back(4'h3);
    drain(30, n);
    cyc(WATCHDOG_CYC + 350);
    check(data_out === 4'h3, "idle lane lost level");
    a_rise();
    cyc(5);
    over_current = 1'b1;
    cyc(1);
    over_current = 1'b0;
    w1 = 0;
    repeat (60) begin
      w1 += int'(primary_switch_a);
      cyc(1);
    end
    check(w1 == 0, "pulse not cut by current limit");
    short_detect = 1'b1;
    cyc(1);
    check(conv_mode === CV_HICCUP && primary_switch_a === 1'b0
          && primary_switch_b === 1'b0, "short not stopping drive");
    wait_mode(CV_SOFT, HC + 10, n);
    check(n == HC, "off time wrong");
    cyc(1);
    check(conv_mode === CV_HICCUP, "lasting short not repeated");
    short_detect = 1'b0;
    wait_mode(CV_NORMAL, 6000, n);
    check(conv_mode === CV_NORMAL, "no recovery after short");
    supply.temp_trip = 1'b1;
    exp_q.push_back(4'h0);
    drain(4, n);
    check(conv_mode === CV_OFF, "converter ran hot");
    supply.temp_trip = 1'b0;
    cyc(20);
    check(data_out === 4'h0 && conv_mode === CV_OFF, "early re-enable");
    supply.temp_clear = 1'b1;
    exp_q.push_back(4'h3);
    drain(REFRESH_CYC + 12, n);
    // Primary power fails; the secondary holds until its watchdog gives up.
    supply.pri_ok = 1'b0;
    exp_q.push_back(4'h0);
    drain(WATCHDOG_CYC + 12, n);
    check(n > WATCHDOG_CYC - REFRESH_CYC - 12, "output not held");
    check(conv_mode === CV_OFF && primary_switch_a === 1'b0
          && primary_switch_b === 1'b0, "converter still on");
    final_report();
  end
endmodule : tb
